// file: core/ridu_pkg.sv
// package: constants and types for the rtc divider, interrupt and update core
package ridu_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_SEC     = 6'h00;
    localparam logic [5:0] IDX_SEC_AL  = 6'h01;
    localparam logic [5:0] IDX_MIN     = 6'h02;
    localparam logic [5:0] IDX_MIN_AL  = 6'h03;
    localparam logic [5:0] IDX_HR      = 6'h04;
    localparam logic [5:0] IDX_HR_AL   = 6'h05;
    localparam logic [5:0] IDX_DOW     = 6'h06;
    localparam logic [5:0] IDX_DOM     = 6'h07;
    localparam logic [5:0] IDX_MON     = 6'h08;
    localparam logic [5:0] IDX_YR      = 6'h09;
    localparam logic [5:0] IDX_RATE    = 6'h0a;
    localparam logic [5:0] IDX_CTRL    = 6'h0b;
    localparam logic [5:0] IDX_FLAG    = 6'h0c;
    localparam logic [5:0] IDX_VALID   = 6'h0d;
    localparam int         RAM_DEPTH   = 64;
    // divider select codes, chain length, skip and tap constants
    localparam logic [2:0] DV_4M       = 3'h0;
    localparam logic [2:0] DV_1M       = 3'h1;
    localparam logic [2:0] DV_32K      = 3'h2;
    localparam logic [1:0] DV_RST_TOP  = 2'h3;
    localparam int         DIV_STAGES  = 22;
    localparam logic [4:0] SKIP_4M     = 5'h00;
    localparam logic [4:0] SKIP_1M     = 5'h02;
    localparam logic [4:0] SKIP_32K    = 5'h07;
    localparam logic [4:0] TAP_BASE    = 5'h05;
    localparam logic [4:0] TAP_BASE_32K = 5'h0c;
    localparam logic [3:0] RS_SLOW_32K = 4'h2;
    // reset values and fixed read data
    localparam logic [2:0] DV_RESET    = 3'h6;
    localparam logic [3:0] RS_RESET    = 4'h0;
    localparam logic [7:0] VALID_VALUE = 8'h80;
    localparam logic [7:0] UNDEF_READ  = 8'hff;
    // timing
    localparam int         CLK_MHZ     = 40;
    localparam int         TBUC_US     = 244;
    localparam int         UC_FAST_US  = 248;
    localparam int         UC_SLOW_US  = 1984;
    localparam int         TBUC_CYC    = TBUC_US * CLK_MHZ;
    localparam int         UC_FAST_CYC = UC_FAST_US * CLK_MHZ;
    localparam int         UC_SLOW_CYC = UC_SLOW_US * CLK_MHZ;
    localparam int         TMR_W       = 17;

    typedef struct packed {
        logic pf;
        logic af;
        logic uf;
    } ridu_irq_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hr;
        logic [7:0] dow;
        logic [7:0] dom;
        logic [7:0] mon;
        logic [7:0] yr;
    } ridu_time_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PRE,
        ST_UPD
    } ridu_state_t;
endpackage

// file: core/ridu_core.sv
// real-time clock core: divider chain, rate selector, update cycle, flags, wishbone slave
`timescale 1ns/1ps
`default_nettype none
module ridu_core
    import ridu_pkg::*;
#(
    parameter int TBUC_CYCLES    = TBUC_CYC,
    parameter int UC_FAST_CYCLES = UC_FAST_CYC,
    parameter int UC_SLOW_CYCLES = UC_SLOW_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        osc_i,
    output logic             square_wave_pin_o,
    output logic             irq_n_o,
    output logic             irq_oe_o
);
    function automatic logic [4:0] skip_bits(input logic [2:0] dv);
        return (dv == DV_1M) ? SKIP_1M : (dv == DV_32K) ? SKIP_32K : SKIP_4M;
    endfunction
    function automatic logic [4:0] tap_bit(input logic [3:0] rs, input logic [2:0] dv);
        return 5'(rs) + ((dv == DV_32K && rs <= RS_SLOW_32K) ? TAP_BASE_32K : TAP_BASE);
    endfunction
    function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
        if (mon == 8'h02) begin
            return (yr[1:0] == 2'h0) ? 8'h1d : 8'h1c;
        end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h0b) begin
            return 8'h1e;
        end
        return 8'h1f;
    endfunction
    // binary 24-hour counting; wraps carry one field at a time
    function automatic ridu_time_t advance(input ridu_time_t t);
        ridu_time_t n;
        n = t;
        n.sec = t.sec + 8'h01;
        if (n.sec >= 8'h3c) begin
            n.sec = 8'h00;
            n.min = t.min + 8'h01;
            if (n.min >= 8'h3c) begin
                n.min = 8'h00;
                n.hr  = t.hr + 8'h01;
                if (n.hr >= 8'h18) begin
                    n.hr  = 8'h00;
                    n.dow = (t.dow >= 8'h07) ? 8'h01 : t.dow + 8'h01;
                    n.dom = t.dom + 8'h01;
                    if (n.dom > days_in(t.mon, t.yr)) begin
                        n.dom = 8'h01;
                        n.mon = t.mon + 8'h01;
                        if (n.mon > 8'h0c) begin
                            n.mon = 8'h01;
                            n.yr  = (t.yr >= 8'h63) ? 8'h00 : t.yr + 8'h01;
                        end
                    end
                end
            end
        end
        return n;
    endfunction
    function automatic logic al_match(input logic [7:0] al, input logic [7:0] t);
        return (al[7:6] == 2'h3) || (al == t);
    endfunction
    logic [7:0]       ram_q [RAM_DEPTH];
    logic [2:0]       dv_q;
    logic [3:0]       rs_q;
    logic             set_q;
    ridu_irq_t        en_q;
    logic             square_wave_output_enable_q;
    logic             dm_q;
    logic             h24_q;
    logic             dse_q;
    ridu_irq_t        flag_q;
    ridu_irq_t        evt;
    logic             osc_s1_q;
    logic             osc_s2_q;
    logic             osc_s3_q;
    logic [DIV_STAGES-1:0] div_q;
    logic             b21_q;
    logic             tap_q;
    logic             tap_now;
    logic             div_rst;
    logic             dv_valid;
    logic             run_ok;
    ridu_state_t      st_q;
    logic [TMR_W-1:0] tmr_q;
    logic [TMR_W-1:0] uc_last;
    logic             upd_done;
    logic             uip_q;
    logic             ack_q;
    logic [31:0]      dat_q;
    logic             irq_oe_q;
    logic             irq_n_q;
    logic             sqw_q;
    logic             req;
    logic             wr;
    logic             rd_flag;
    logic [5:0]       idx;
    ridu_time_t       cur_t;
    ridu_time_t       nxt_t;

    assign req      = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr       = req && wb_we_i && wb_sel_i[0];
    assign idx      = wb_adr_i[7:2];
    assign rd_flag  = req && !wb_we_i && idx == IDX_FLAG;
    assign div_rst  = dv_q[2:1] == DV_RST_TOP;
    assign dv_valid = dv_q == DV_4M || dv_q == DV_1M || dv_q == DV_32K;
    assign run_ok   = dv_valid && !set_q;
    assign uc_last  = (dv_q == DV_32K) ? TMR_W'(UC_SLOW_CYCLES - 1)
                                       : TMR_W'(UC_FAST_CYCLES - 1);
    assign upd_done = st_q == ST_UPD && run_ok && tmr_q == uc_last;
    assign tap_now  = rs_q != 4'h0 && div_q[tap_bit(rs_q, dv_q)];
    assign cur_t    = '{ram_q[IDX_SEC], ram_q[IDX_MIN], ram_q[IDX_HR], ram_q[IDX_DOW],
                        ram_q[IDX_DOM], ram_q[IDX_MON], ram_q[IDX_YR]};
    assign nxt_t    = advance(cur_t);
    assign evt.pf = tap_now && !tap_q;
    assign evt.uf = upd_done;
    assign evt.af = upd_done && al_match(ram_q[IDX_SEC_AL], nxt_t.sec)
                             && al_match(ram_q[IDX_MIN_AL], nxt_t.min)
                             && al_match(ram_q[IDX_HR_AL], nxt_t.hr);
    // time base crosses in from the pin; the second and third stages feed the edge detect
    always_ff @(posedge clk_i) begin
        osc_s1_q <= osc_i;
        osc_s2_q <= osc_s1_q;
        osc_s3_q <= osc_s2_q;
    end
    // bypassed stages modelled by adding 2^skip per time-base edge
    always_ff @(posedge clk_i) begin
        if (rst_i || div_rst) begin
            div_q <= '0;
            b21_q <= 1'b0;
            tap_q <= 1'b0;
        end else begin
            if (dv_valid && osc_s2_q && !osc_s3_q) begin
                div_q <= div_q + (DIV_STAGES'(1) << skip_bits(dv_q));
            end
            b21_q <= div_q[DIV_STAGES-1];
            tap_q <= tap_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sqw_q <= 1'b0;
        end else begin
            sqw_q <= square_wave_output_enable_q && tap_now && !div_rst;
        end
    end
    // 1 hz tick is the rise of the top stage, half a second after divider release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q  <= ST_IDLE;
            tmr_q <= '0;
            uip_q <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    tmr_q <= '0;
                    if (run_ok && div_q[DIV_STAGES-1] && !b21_q) begin
                        st_q  <= ST_PRE;
                        uip_q <= 1'b1;
                    end
                end
                ST_PRE: begin
                    if (!run_ok) begin
                        st_q  <= ST_IDLE;
                        uip_q <= 1'b0;
                    end else if (tmr_q == TMR_W'(TBUC_CYCLES - 1)) begin
                        st_q  <= ST_UPD;
                        tmr_q <= '0;
                    end else begin
                        tmr_q <= tmr_q + TMR_W'(1);
                    end
                end
                ST_UPD: begin
                    if (!run_ok || upd_done) begin
                        st_q  <= ST_IDLE;
                        uip_q <= 1'b0;
                    end else begin
                        tmr_q <= tmr_q + TMR_W'(1);
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
    // time bytes locked out during update; user ram shares the chain but no index overlaps, so no write is lost
    always_ff @(posedge clk_i) begin
        if (upd_done) begin
            ram_q[IDX_SEC] <= nxt_t.sec;
            ram_q[IDX_MIN] <= nxt_t.min;
            ram_q[IDX_HR]  <= nxt_t.hr;
            ram_q[IDX_DOW] <= nxt_t.dow;
            ram_q[IDX_DOM] <= nxt_t.dom;
            ram_q[IDX_MON] <= nxt_t.mon;
            ram_q[IDX_YR]  <= nxt_t.yr;
        end
        if (wr && idx == IDX_SEC && st_q != ST_UPD) begin
            ram_q[IDX_SEC] <= {1'b0, wb_dat_i[6:0]};
        end else if (wr && idx <= IDX_YR && st_q != ST_UPD) begin
            ram_q[idx] <= wb_dat_i[7:0];
        end else if (wr && idx > IDX_VALID) begin
            ram_q[idx] <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dv_q   <= DV_RESET;
            rs_q   <= RS_RESET;
            set_q  <= 1'b0;
            en_q   <= '0;
            square_wave_output_enable_q <= 1'b0;
            dm_q   <= 1'b0;
            h24_q  <= 1'b0;
            dse_q  <= 1'b0;
        end else if (wr && idx == IDX_RATE) begin
            dv_q <= wb_dat_i[6:4];
            rs_q <= wb_dat_i[3:0];
        end else if (wr && idx == IDX_CTRL) begin
            set_q   <= wb_dat_i[7];
            en_q.pf <= wb_dat_i[6];
            en_q.af <= wb_dat_i[5];
            en_q.uf <= wb_dat_i[4] && !wb_dat_i[7];
            square_wave_output_enable_q  <= wb_dat_i[3];
            dm_q    <= wb_dat_i[2];
            h24_q   <= wb_dat_i[1];
            dse_q   <= wb_dat_i[0];
        end
    end
    // a read clears what it returned; an event in the same edge still lands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= '0;
        end else if (rd_flag) begin
            flag_q <= evt;
        end else begin
            flag_q <= flag_q | evt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_oe_q <= 1'b0;
            irq_n_q  <= 1'b1;
        end else begin
            irq_oe_q <= |(flag_q & en_q);
            irq_n_q  <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                if (idx <= IDX_YR && st_q == ST_UPD) begin
                    dat_q <= {24'h0, UNDEF_READ};
                end else if (idx == IDX_RATE) begin
                    dat_q <= {24'h0, uip_q, dv_q, rs_q};
                end else if (idx == IDX_CTRL) begin
                    dat_q <= {24'h0, set_q, en_q.pf, en_q.af, en_q.uf,
                              square_wave_output_enable_q, dm_q, h24_q, dse_q};
                end else if (idx == IDX_FLAG) begin
                    dat_q <= {24'h0, irq_oe_q, flag_q.pf, flag_q.af, flag_q.uf, 4'h0};
                end else if (idx == IDX_VALID) begin
                    dat_q <= {24'h0, VALID_VALUE};
                end else begin
                    dat_q <= {24'h0, ram_q[idx]};
                end
            end
        end
    end

    assign wb_dat_o          = dat_q;
    assign wb_ack_o          = ack_q;
    assign square_wave_pin_o = sqw_q;
    assign irq_n_o           = irq_n_q;
    assign irq_oe_o          = irq_oe_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_irq_on;
        |(flag_q & en_q) |=> irq_oe_o && !irq_n_o;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq not asserted");
    property p_irq_off;
        !(|(flag_q & en_q)) |=> !irq_oe_o;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq without cause");
    property p_uip_upd;
        st_q == ST_UPD |-> uip_q;
    endproperty
    a_uip_upd: assert property (p_uip_upd) else $error("uip low in update");
    property p_set_abort;
        wr && idx == IDX_CTRL && wb_dat_i[7] |=> ##1 st_q == ST_IDLE && !uip_q;
    endproperty
    a_set_abort: assert property (p_set_abort) else $error("set did not abort");
    property p_uf_cause;
        $rose(flag_q.uf) |-> $past(st_q) == ST_UPD && st_q == ST_IDLE;
    endproperty
    a_uf_cause: assert property (p_uf_cause) else $error("uf without update");
    property p_div_quiet;
        div_rst && $past(div_rst) |-> !square_wave_pin_o && !evt.pf;
    endproperty
    a_div_quiet: assert property (p_div_quiet) else $error("activity in reset");
    property p_flag_clear;
        rd_flag && flag_q.af && !evt.af |=> !flag_q.af;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
    property p_set_block;
        st_q == ST_IDLE && set_q |=> st_q == ST_IDLE;
    endproperty
    a_set_block: assert property (p_set_block) else $error("update while set");
    // a set-bit abort may cut the pre-update short, so only uninterrupted runs count
    property p_pre_len;
        $rose(uip_q) ##0 run_ok [*7] |=> st_q == ST_PRE;
    endproperty
    a_pre_len: assert property (p_pre_len) else $error("pre-update too short");
    c_update: cover property (upd_done);
    c_alarm: cover property (evt.af);
    c_flag_read: cover property (rd_flag && flag_q != '0);
    c_sqw: cover property ($rose(square_wave_pin_o));
endmodule // ridu_core
`default_nettype wire

// file: verification/ridu_pins_model.sv
// pin-side model: time base crystal and interrupt line pull-up
`timescale 1ns/1ps
`default_nettype none
module ridu_pins_model #(
    parameter real HALF_NS = 56.0
) (
    input  wire logic irq_n_i,
    input  wire logic irq_oe_i,
    output var logic  osc_o,
    output logic      irq_wire_o
);
    // crystal runs free; period kept above four core clocks for the synchroniser
    initial begin
        osc_o = 1'b0;
        forever #(HALF_NS) osc_o = ~osc_o;
    end
    // open-drain line, pull-up when released
    assign irq_wire_o = irq_oe_i ? irq_n_i : 1'b1;
endmodule // ridu_pins_model
`default_nettype wire

// file: verification/ridu_core_tb.sv
// self-checking bench for the rtc divider, interrupt and update core
`timescale 1ns/1ps
`default_nettype none
module ridu_core_tb;
    import ridu_pkg::*;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        osc;
    logic        square_wave_pin;
    logic        irq_n;
    logic        irq_oe;
    logic        irq_wire;
    logic [7:0]  rd;
    int          mismatches = 0;
    int          tests_run = 0;
    int          r;
    int          q;
    int          n;
    realtime     t0;
    realtime     t1;
    logic [5:0]  s_idx [6] = '{6'h0e, 6'h3f, IDX_FLAG, IDX_VALID, IDX_SEC, IDX_RATE};
    logic [7:0]  s_wr  [6] = '{8'ha5, 8'h5a, 8'hff, 8'h00, 8'hbb, 8'he0};
    logic [7:0]  s_exp [6] = '{8'ha5, 8'h5a, 8'h00, VALID_VALUE, 8'h3b, 8'h60};
    logic [7:0]  t_set [10] = '{8'h3b, 8'hc0, 8'h3b, 8'hc0, 8'h17, 8'hc0, 8'h07, 8'h1f, 8'h0c, 8'h10};
    logic [7:0]  t_exp [10] = '{8'h00, 8'hc0, 8'h00, 8'hc0, 8'h00, 8'hc0, 8'h01, 8'h01, 8'h01, 8'h11};

    // short pre/update counts keep the run inside budget
    ridu_core #(.TBUC_CYCLES(10), .UC_FAST_CYCLES(12), .UC_SLOW_CYCLES(40)) ridu_core_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_i(osc),
        .square_wave_pin_o(square_wave_pin), .irq_n_o(irq_n), .irq_oe_o(irq_oe));
    ridu_pins_model ridu_pins_model_i (
        .irq_n_i(irq_n), .irq_oe_i(irq_oe), .osc_o(osc), .irq_wire_o(irq_wire));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ok(input bit c);
        check({7'h0, c}, 8'h01);
    endtask

    // classic cycle: request held until ack is sampled high
    task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d);
        int k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            k++;
            if (k > 20) begin
                mismatches++;
                close_out();
            end
            @(posedge clk_i);
        end
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic rc(input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask

    task automatic watch(input int cyc, output int rises, output int irqs);
        logic prev = 1'b0;
        rises = 0;
        irqs = 0;
        repeat (cyc) begin
            @(posedge clk_i);
            if (square_wave_pin === 1'b1 && prev !== 1'b1) rises++;
            if (irq_oe !== 1'b0) irqs++;
            prev = square_wave_pin;
        end
    endtask

    task automatic poll_uip(input logic lvl, input int lim);
        n = 0;
        do begin
            bus(1'b0, IDX_RATE, 8'h00);
            n++;
        end while (rd[7] !== lvl && n < lim);
        if (n >= lim) begin
            mismatches++;
            close_out();
        end
    endtask

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(IDX_RATE, 8'h60);
        rc(IDX_CTRL, 8'h00);
        rc(IDX_FLAG, 8'h00);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, s_idx[i], s_wr[i]);
            rc(s_idx[i], s_exp[i]);
        end
        wb_sel_i <= 4'h0;
        bus(1'b1, 6'h0e, 8'h11);
        wb_sel_i <= 4'h1;
        rc(6'h0e, 8'ha5);
        // divider held in reset: nothing may toggle
        bus(1'b1, IDX_CTRL, 8'h48);
        bus(1'b1, IDX_RATE, 8'h63);
        watch(448, r, q);
        ok(r == 0 && q == 0);
        rc(IDX_FLAG, 8'h00);
        // 32.768 khz base, fastest tap: four base periods per square-wave period
        bus(1'b1, IDX_CTRL, 8'h08);
        bus(1'b1, IDX_RATE, 8'h23);
        t0 = $realtime;
        watch(448, r, q);
        ok(r >= 24 && r <= 26);
        ok(q == 0);
        bus(1'b1, IDX_CTRL, 8'h48);
        repeat (3) @(posedge clk_i);
        ok(irq_oe === 1'b1 && irq_wire === 1'b0);
        rc(IDX_FLAG, 8'hc0);
        bus(1'b1, IDX_CTRL, 8'h40);
        watch(448, r, q);
        ok(r == 0 && q > 0);
        bus(1'b1, IDX_RATE, 8'h20);
        bus(1'b0, IDX_FLAG, 8'h00);
        watch(200, r, q);
        ok(r == 0 && q == 0);
        rc(IDX_FLAG, 8'h00);
        // load time with set held, then release for the first update
        bus(1'b1, IDX_CTRL, 8'h80);
        for (int i = 0; i < 10; i++) bus(1'b1, i[5:0], t_set[i]);
        bus(1'b1, IDX_CTRL, 8'h30);
        poll_uip(1'b1, 30000);
        ok($realtime - t0 > 1834000.0 && $realtime - t0 < 1837000.0);
        t1 = $realtime;
        rc(IDX_SEC, 8'h3b);
        repeat (12) @(posedge clk_i);
        rc(IDX_SEC, UNDEF_READ);
        rc(IDX_RATE, 8'ha0);
        rc(6'h0e, 8'ha5);
        poll_uip(1'b0, 100);
        // uip spans pre (10) plus slow update (40) cycles, seen through 3-cycle polls
        ok($realtime - t1 > 1150.0 && $realtime - t1 < 1300.0);
        for (int i = 0; i < 10; i++) rc(i[5:0], t_exp[i]);
        ok(irq_oe === 1'b1);
        rc(IDX_FLAG, 8'hb0);
        rc(IDX_FLAG, 8'h00);
        ok(irq_oe === 1'b0 && irq_wire === 1'b1);
        close_out();
    end

    initial begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        close_out();
    end
endmodule // ridu_core_tb
`default_nettype wire
